// ===== verilog/ee_serial_eeprom.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Sample data on clock rise, change output after clock fall, open-drain.
// - Data fall with clock high is START, data rise is STOP.
// - Ignore all activity until a START has been seen.
// - A zero pulls the data line low, a one releases it.
// - Address byte: 1010, three select pins, then read/write bit.
// - Acknowledge matching address, both address bytes and data unless write protected.
// - Read: send eight bits, release on ninth, continue while acknowledged.
// - Two address bytes: top two ignored, 8-bit page, 6-bit offset.
// - Data bytes fill the page buffer; STOP starts the write cycle.
// - During the write cycle keep data released, ignore requests.
// - Up to 64 bytes; offset wraps inside the latched page.
// - Only bytes of the latest page sequence are committed.
// - Do not acknowledge the slave address while writing.
// - Sample write protect at last fall before first data byte.
// - Memory starts erased, every byte reads FFh.
// - Read address: acknowledge, send byte at current address.
// - Selective read: address bytes, repeated START, read from there.
// - Acknowledged read bytes continue from successive addresses.
// - Sequential read address wraps at end of memory, not page.
module ee_serial_eeprom
    import ee_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_COUNT  // Write cycle clocks.
) (
    input  wire logic mclk,                 // System clock, 50 MHz.
    input  wire logic rst,                  // Synchronous reset, high.
    input  wire logic sclIn,                // Serial clock pin.
    input  wire logic sdaIn,                // Serial data pin level.
    output logic      sdaOut,               // Data pin drive value.
    output logic      sdaOe,                // High while pulling data low.
    input  wire logic deviceSelectBit0Pin,  // Select strap, bit 0.
    input  wire logic deviceSelectBit1Pin,  // Select strap, bit 1.
    input  wire logic deviceSelectBit2Pin,  // Select strap, bit 2.
    input  wire logic writeProtectPin,      // High blocks writes.
    output logic      writeBusy             // Internal write cycle running.
);
    // ------------------------------------------------------------------------
    // Line conditioning
    // ------------------------------------------------------------------------
    logic sclLevel, sclRise, sclFall;
    logic sdaLevel, sdaRise, sdaFall;
    logic busy;

    ee_line_filter u_scl (
        .mclk   (mclk),
        .rst    (rst),
        .lineIn (sclIn),
        .level  (sclLevel),
        .rise   (sclRise),
        .fall   (sclFall)
    );

    ee_line_filter u_sda (
        .mclk   (mclk),
        .rst    (rst),
        .lineIn (sdaIn),
        .level  (sdaLevel),
        .rise   (sdaRise),
        .fall   (sdaFall)
    );

    logic       startCond, stopCond;
    logic [2:0] selA_reg, selB_reg;
    logic       wpA_reg, wpB_reg;

    assign startCond = sdaFall && sclLevel && !sclFall;
    assign stopCond  = sdaRise && sclLevel && !sclFall;

    // Straps and write protect are pins, so they are synchronised too.
    always_ff @(posedge mclk) begin
        if (rst) begin
            selA_reg <= 3'h0;
            selB_reg <= 3'h0;
            wpA_reg  <= 1'b0;
            wpB_reg  <= 1'b0;
        end else begin
            selA_reg <= {deviceSelectBit2Pin, deviceSelectBit1Pin,
                         deviceSelectBit0Pin};
            selB_reg <= selA_reg;
            wpA_reg  <= writeProtectPin;
            wpB_reg  <= wpA_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // erased delivery state
    // Cells hold each byte XOR the erased value in two-state storage,
    // which starts at zero, so an untouched byte reads back erased and
    // the array has a single writer instead of a preset process beside
    // the commit engine.
    bit   [7:0] memCell  [0:MEM_BYTES-1];

    // Page buffer for the bytes of one write sequence.
    logic [7:0] pageBuf  [0:PAGE_BYTES-1];

    // ------------------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------------------
    ee_state_e           state_reg, state_next;
    ee_state_e           pend_reg, pend_next;
    logic [3:0]          bitCnt_reg, bitCnt_next;
    logic                ackPh_reg, ackPh_next;
    logic                mAck_reg, mAck_next;
    logic [7:0]          shift_reg, shift_next;
    logic [7:0]          tx_reg, tx_next;
    logic [ADDR_W-1:0]   addr_reg, addr_next;
    logic [ADDR_HI_USED-1:0] addrHi_reg, addrHi_next;
    logic [PAGE_W-1:0]   page_reg, page_next;
    logic [OFFS_W-1:0]   offs_reg, offs_next;
    logic [PAGE_BYTES-1:0] valid_reg, valid_next;
    logic                loaded_reg, loaded_next;
    logic                wp_reg, wp_next;
    logic                oe_reg, oe_next;
    logic                commitGo;
    logic                bufWe;
    logic [7:0]          rdByte;

    assign rdByte = memCell[addr_reg] ^ ERASED_BYTE;

    // Matching of the received address byte against type code and straps.
    function automatic logic addrMatch(input logic [7:0] b,
                                       input logic [2:0] sel);
        return (b[7:DEV_TYPE_LSB] == DEV_TYPE_CODE) &&
               (b[DEV_TYPE_LSB-1:DEV_SEL_LSB] == sel);
    endfunction

    // Next-state logic: received bytes are shifted in on clock rise and the data pin
    // only changes on clock fall, so the master sees it stable while high.
    always_comb begin
        state_next  = state_reg;
        pend_next   = pend_reg;
        bitCnt_next = bitCnt_reg;
        ackPh_next  = ackPh_reg;
        mAck_next   = mAck_reg;
        shift_next  = shift_reg;
        tx_next     = tx_reg;
        addr_next   = addr_reg;
        addrHi_next = addrHi_reg;
        page_next   = page_reg;
        offs_next   = offs_reg;
        valid_next  = valid_reg;
        loaded_next = loaded_reg;
        wp_next     = wp_reg;
        oe_next     = oe_reg;
        commitGo    = 1'b0;
        bufWe       = 1'b0;
        if (startCond) begin
            state_next  = ST_DEV;
            bitCnt_next = 4'h0;
            ackPh_next  = 1'b0;
            oe_next     = 1'b0;
        end else if (stopCond) begin
            if (state_reg == ST_WDATA && loaded_reg) begin
                commitGo = 1'b1;
            end
            loaded_next = 1'b0;
            state_next  = ST_IDLE;
            oe_next     = 1'b0;
        end else if (state_reg == ST_RDATA) begin
            if (sclRise) begin
                if (ackPh_reg) begin
                    mAck_next = !sdaLevel;
                end else begin
                    bitCnt_next = bitCnt_reg + 4'h1;
                end
            end else if (sclFall) begin
                if (ackPh_reg) begin
                    ackPh_next  = 1'b0;
                    bitCnt_next = 4'h0;
                    if (mAck_reg) begin
                        tx_next   = {rdByte[6:0], 1'b0};
                        oe_next   = !rdByte[7];
                        addr_next = addr_reg + 1'b1;
                    end else begin
                        state_next = ST_SKIP;
                        oe_next    = 1'b0;
                    end
                end else if (bitCnt_reg == BITS_PER_BYTE) begin
                    oe_next    = 1'b0;
                    ackPh_next = 1'b1;
                end else begin
                    oe_next = !tx_reg[7];
                    tx_next = {tx_reg[6:0], 1'b0};
                end
            end
        end else if (state_reg == ST_DEV || state_reg == ST_AHI ||
                     state_reg == ST_ALO || state_reg == ST_WDATA) begin
            if (sclRise && !ackPh_reg && bitCnt_reg != BITS_PER_BYTE) begin
                shift_next  = {shift_reg[6:0], sdaLevel};
                bitCnt_next = bitCnt_reg + 4'h1;
            end else if (sclFall && ackPh_reg) begin
                oe_next     = 1'b0;
                ackPh_next  = 1'b0;
                bitCnt_next = 4'h0;
                state_next  = pend_reg;
                if (state_reg == ST_ALO) begin
                    wp_next = wpB_reg;
                end
                if (pend_reg == ST_RDATA) begin
                    tx_next   = {rdByte[6:0], 1'b0};
                    oe_next   = !rdByte[7];
                    addr_next = addr_reg + 1'b1;
                end
            end else if (sclFall && bitCnt_reg == BITS_PER_BYTE) begin
                ackPh_next = 1'b1;
                oe_next    = 1'b1;
                unique case (state_reg)
                    ST_DEV: begin
                        if (!addrMatch(shift_reg, selB_reg) || busy) begin
                            ackPh_next = 1'b0;
                            oe_next    = 1'b0;
                            state_next = ST_SKIP;
                        end else if (shift_reg[RW_BIT]) begin
                            pend_next = ST_RDATA;
                        end else begin
                            pend_next = ST_AHI;
                        end
                    end
                    ST_AHI: begin
                        addrHi_next = shift_reg[ADDR_HI_USED-1:0];
                        pend_next   = ST_ALO;
                    end
                    ST_ALO: begin
                        addr_next = {addrHi_reg, shift_reg};
                        page_next = {addrHi_reg, shift_reg[7:OFFS_W]};
                        offs_next = shift_reg[OFFS_W-1:0];
                        valid_next  = '0;
                        loaded_next = 1'b0;
                        pend_next   = ST_WDATA;
                    end
                    default: begin
                        if (wp_reg) begin
                            ackPh_next  = 1'b0;
                            oe_next     = 1'b0;
                            loaded_next = 1'b0;
                            state_next  = ST_SKIP;
                        end else begin
                            bufWe                = 1'b1;
                            valid_next[offs_reg] = 1'b1;
                            loaded_next          = 1'b1;
                            offs_next            = offs_reg + 6'h01;
                            addr_next = {page_reg, offs_reg + 6'h01};
                            pend_next            = ST_WDATA;
                        end
                    end
                endcase
            end
        end
    end

    // Protocol state registers.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg  <= ST_IDLE;
            pend_reg   <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            ackPh_reg  <= 1'b0;
            mAck_reg   <= 1'b0;
            shift_reg  <= 8'h00;
            tx_reg     <= 8'h00;
            addr_reg   <= '0;
            addrHi_reg <= '0;
            page_reg   <= '0;
            offs_reg   <= '0;
            valid_reg  <= '0;
            loaded_reg <= 1'b0;
            wp_reg     <= 1'b0;
            oe_reg     <= 1'b0;
        end else begin
            state_reg  <= state_next;
            pend_reg   <= pend_next;
            bitCnt_reg <= bitCnt_next;
            ackPh_reg  <= ackPh_next;
            mAck_reg   <= mAck_next;
            shift_reg  <= shift_next;
            tx_reg     <= tx_next;
            addr_reg   <= addr_next;
            addrHi_reg <= addrHi_next;
            page_reg   <= page_next;
            offs_reg   <= offs_next;
            valid_reg  <= valid_next;
            loaded_reg <= loaded_next;
            wp_reg     <= wp_next;
            oe_reg     <= oe_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (bufWe) begin
            pageBuf[offs_reg] <= shift_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Write cycle
    // ------------------------------------------------------------------------
    logic              copy_reg, copy_next;
    logic [OFFS_W-1:0] copyIdx_reg, copyIdx_next;

    ee_write_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .mclk  (mclk),
        .rst   (rst),
        .start (commitGo),
        .busy  (busy)
    );

    // The copy walks the page in 64 clocks, far inside the write cycle,
    // so the buffer is never reloaded while it is still being drained.
    always_comb begin
        copy_next    = copy_reg;
        copyIdx_next = copyIdx_reg;
        if (commitGo) begin
            copy_next    = 1'b1;
            copyIdx_next = '0;
        end else if (copy_reg) begin
            copyIdx_next = copyIdx_reg + 6'h01;
            if (copyIdx_reg == LAST_OFFSET) begin
                copy_next = 1'b0;
            end
        end
    end

    // Copy engine state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            copy_reg    <= 1'b0;
            copyIdx_reg <= '0;
        end else begin
            copy_reg    <= copy_next;
            copyIdx_reg <= copyIdx_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (copy_reg && valid_reg[copyIdx_reg]) begin
            memCell[{page_reg, copyIdx_reg}] <=
                pageBuf[copyIdx_reg] ^ ERASED_BYTE;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    logic sdaOut_reg;

    // The pin is open-drain: the driven value is always low.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sdaOut_reg <= 1'b0;
        end else begin
            sdaOut_reg <= 1'b0;
        end
    end

    assign sdaOut    = sdaOut_reg;
    assign sdaOe     = oe_reg;
    assign writeBusy = busy;
endmodule // ee_serial_eeprom
`default_nettype wire

// ===== verilog/ee_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants of the serial memory slave
// ----------------------------------------------------------------------------
package ee_pkg;
    // Clock and timing.
    localparam int MCLK_PERIOD_NS      = 20;
    localparam int MCLK_PER_US         = 1000 / MCLK_PERIOD_NS;
    // Deglitch window; a least time, so it rounds up.
    localparam int FILTER_TIME_NS      = 40;
    localparam int FILTER_CYCLES       =
        (FILTER_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // Internal write cycle time; a longest time, so it rounds down.
    localparam int WRITE_CYCLE_TIME_US = 5000;
    localparam int WRITE_CYCLE_COUNT   = WRITE_CYCLE_TIME_US * MCLK_PER_US;

    // Address layout.
    localparam int ADDR_W              = 14;
    localparam int PAGE_W              = 8;
    localparam int OFFS_W              = 6;
    localparam int ADDR_HI_USED        = ADDR_W - 8;
    localparam int PAGE_BYTES          = 64;
    localparam int MEM_BYTES           = 16384;

    // Slave address byte fields.
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    localparam int DEV_TYPE_LSB        = 4;
    localparam int DEV_SEL_LSB         = 1;
    localparam int RW_BIT              = 0;

    // Values.
    localparam logic [7:0] ERASED_BYTE    = 8'hff;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [5:0] LAST_OFFSET    = 6'h3f;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_DEV   = 3'h1,
        ST_AHI   = 3'h2,
        ST_ALO   = 3'h3,
        ST_WDATA = 3'h4,
        ST_RDATA = 3'h5,
        ST_SKIP  = 3'h6
    } ee_state_e;
endpackage
`default_nettype wire

// ===== verilog/ee_line_filter.sv
`timescale 1ns/1ps
`default_nettype none
module ee_line_filter
    import ee_pkg::*;
(
    input  wire logic mclk,    // System clock.
    input  wire logic rst,     // Synchronous reset, active high.
    input  wire logic lineIn,  // Raw bus line.
    output logic      level,   // Clean line level.
    output logic      rise,    // One-cycle pulse on a clean rise.
    output logic      fall     // One-cycle pulse on a clean fall.
);
    localparam logic [3:0] FILT_LAST = 4'(FILTER_CYCLES - 1);

    logic       syncA_reg;
    logic       syncB_reg;
    logic       level_reg, level_next;
    logic       rise_reg, rise_next;
    logic       fall_reg, fall_next;
    logic [3:0] cnt_reg, cnt_next;

    // A new level is taken only once it has stood for the whole window,
    // which swallows spikes shorter than that window.
    always_comb begin
        level_next = level_reg;
        cnt_next   = 4'h0;
        rise_next  = 1'b0;
        fall_next  = 1'b0;
        if (syncB_reg != level_reg) begin
            if (cnt_reg == FILT_LAST) begin
                level_next = syncB_reg;
                rise_next  = syncB_reg;
                fall_next  = !syncB_reg;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    // Two-stage synchroniser and filter state; the idle bus is high.
    always_ff @(posedge mclk) begin
        if (rst) begin
            syncA_reg <= 1'b1;
            syncB_reg <= 1'b1;
            level_reg <= 1'b1;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
            cnt_reg   <= 4'h0;
        end else begin
            syncA_reg <= lineIn;
            syncB_reg <= syncA_reg;
            level_reg <= level_next;
            rise_reg  <= rise_next;
            fall_reg  <= fall_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign level = level_reg;
    assign rise  = rise_reg;
    assign fall  = fall_reg;
endmodule // ee_line_filter
`default_nettype wire

// ===== verilog/ee_write_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ee_write_timer #(
    parameter int CYCLES = 250000  // Length of the write cycle in clocks.
) (
    input  wire logic mclk,   // System clock.
    input  wire logic rst,    // Synchronous reset, active high.
    input  wire logic start,  // One-cycle pulse that opens a write cycle.
    output logic      busy    // High while the write cycle runs.
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);

    logic          busy_reg, busy_next;
    logic [CW-1:0] cnt_reg, cnt_next;

    // Count out the cycle; a start while busy is not expected.
    always_comb begin
        busy_next = busy_reg;
        cnt_next  = cnt_reg;
        if (busy_reg) begin
            if (cnt_reg == CNT_LAST) begin
                busy_next = 1'b0;
                cnt_next  = '0;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end else if (start) begin
            busy_next = 1'b1;
            cnt_next  = '0;
        end
    end

    // Timer state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_reg <= 1'b0;
            cnt_reg  <= '0;
        end else begin
            busy_reg <= busy_next;
            cnt_reg  <= cnt_next;
        end
    end

    assign busy = busy_reg;
endmodule // ee_write_timer
`default_nettype wire

// ===== sim/ee_serial_eeprom_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------
// Slave port checks
// ---------------------
module ee_serial_eeprom_properties #(
    parameter int WRITE_CYCLES = 200  // Busy span.
) (
    input wire logic mclk,      // Clock.
    input wire logic rst,       // Reset.
    input wire logic sclIn,     // Clock pin.
    input wire logic sdaIn,     // Data wire.
    input wire logic sdaOut,    // Drive value.
    input wire logic sdaOe,     // Pull-down.
    input wire logic writeBusy  // Busy flag.
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    int busyReg;
    int busyNext;
    // Busy length is counted, as it is far too long for a repetition.
    always_comb begin
        busyNext = writeBusy ? busyReg + 1 : 0;
    end
    always_ff @(posedge mclk) begin
        busyReg <= rst ? 0 : busyNext;
    end
    pull_low_a: assert property (!sdaOut) else $error("drive high");
    busy_release_a: assert property (writeBusy |-> !sdaOe)
        else $error("drive while busy");
    busy_stop_a: assert property ($rose(writeBusy) |->
        sclIn && sdaIn && $past(sclIn, 8)) else $error("busy no stop");
    busy_span_a: assert property ($fell(writeBusy) |->
        busyReg >= WRITE_CYCLES - 1 && busyReg <= WRITE_CYCLES + 1)
        else $error("busy span");
    idle_quiet_a: assert property (sclIn [*8] |-> !sdaOe)
        else $error("drive on idle");
    ack_hold_a: assert property ($rose(sdaOe) |=> sdaOe [*6])
        else $error("short drive");
    change_low_a: assert property ($changed(sdaOe) |->
        !sclIn && !($past(sclIn, 4) && $past(sclIn, 5) && $past(sclIn, 6)
        && $past(sclIn, 7))) else $error("change in high");
    reset_quiet_a: assert property ($fell(rst) |->
        !sdaOe && !writeBusy) else $error("reset state");
    // Main scenarios reached.
    cover property ($rose(writeBusy));
    cover property ($fell(writeBusy));
    cover property ($rose(sdaOe));
endmodule // ee_serial_eeprom_properties
bind ee_serial_eeprom ee_serial_eeprom_properties #(
    .WRITE_CYCLES(WRITE_CYCLES)) u_props (.mclk(mclk), .rst(rst),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .writeBusy(writeBusy));
`default_nettype wire

// ===== sim/ee_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------
// Two-wire bus master
// ---------------------
module ee_bus_master (
    output logic      sclOut,   // Clock, idle high.
    output logic      pullLow,  // Pulls data low.
    input  wire logic sdaWire   // Data wire level.
);
    // Bus idles released; the clock stands still outside frames.
    initial begin
        sclOut = 1'b1;
        pullLow = 1'b0;
    end
    // stable while high.
    // The low phase outlasts the slave's five-clock answer delay, so its
    // data settles before the clock rises; the high phase is the filter.
    task automatic bitX(input logic b, output logic s);
        #20 pullLow = !b;
        #100 sclOut = 1'b1;
        #36 s = sdaWire;
        #4 sclOut = 1'b0;
    endtask
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            bitX(tx[i], rx[i]);
        end
    endtask
    // START, long low lets the slave let go first.
    task automatic start;
        #140 pullLow = 1'b0;
        #80 sclOut = 1'b1;
        #80 pullLow = 1'b1;
        #80 sclOut = 1'b0;
    endtask
    task automatic stop;
        #140 pullLow = 1'b1;
        #80 sclOut = 1'b1;
        #80 pullLow = 1'b0;
        #400;
    endtask
endmodule // ee_bus_master
`default_nettype wire

// ===== sim/tb_ee_serial_eeprom.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------
// Slave bench
// ---------------------
module tb_ee_serial_eeprom
    import ee_pkg::*;
;
    localparam logic [6:0] DEV = {DEV_TYPE_CODE, 3'h5};
    logic       mclk;
    logic       rst;
    logic       wp;
    logic [2:0] sel;
    logic [8:0] rx;
    int         fails;
    int         compares;
    wire logic  scl;
    wire logic  mLow;
    wire logic  oe;
    wire logic  busy;
    // Open-drain data wire with its pull-up.
    wire logic  sda = !(mLow || oe);
    ee_serial_eeprom #(.WRITE_CYCLES(200)) DUT (.mclk(mclk), .rst(rst),
        .sclIn(scl), .sdaIn(sda), .sdaOut(), .sdaOe(oe),
        .deviceSelectBit0Pin(sel[0]), .deviceSelectBit1Pin(sel[1]),
        .deviceSelectBit2Pin(sel[2]), .writeProtectPin(wp),
        .writeBusy(busy));
    ee_bus_master BM (.sclOut(scl), .pullLow(mLow), .sdaWire(sda));
    // Free-running system clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = !mclk;
    end
    // One compare, reported at once on a mismatch.
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Send byte d; nak is the expected ninth bit.
    task automatic wr(input logic [7:0] d, input logic nak);
        BM.xfer({d, 1'b1}, rx);
        chk(rx, {d, nak});
    endtask
    // Read byte d; a is the master's own answer.
    task automatic rd(input logic [7:0] d, input logic a);
        BM.xfer({8'hff, a}, rx);
        chk(rx, {d, a});
    endtask
    // top bits set, so they must be ignored.
    task automatic point(input logic [13:0] a);
        BM.start;
        wr({DEV, 1'b0}, 1'b0);
        wr({2'h3, a[13:8]}, 1'b0);
        wr(a[7:0], 1'b0);
    endtask
    task automatic fetch(input logic [13:0] a, input logic [7:0] d);
        point(a);
        BM.start;
        wr({DEV, 1'b1}, 1'b0);
        rd(d, 1'b1);
        BM.stop;
    endtask
    task automatic t_select;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1 sel = i[2:0];
            BM.start;
            wr({i[0] ? 4'hb : DEV_TYPE_CODE, i[2:0] ^ {2'h0, !i[0]},
                1'b1}, 1'b1);
            BM.start;
            wr({DEV_TYPE_CODE, i[2:0], 1'b1}, 1'b0);
            rd(ERASED_BYTE, 1'b1);
            BM.stop;
        end
        @(posedge mclk);
        #1 sel = 3'h5;
    endtask
    task automatic t_wrap;
        point(14'h3fff);
        wr(8'h5a, 1'b0);
        wr(8'ha5, 1'b0);
        BM.stop;
        chk({8'h0, busy}, 9'h1);
        BM.start;
        wr({DEV, 1'b0}, 1'b1);
        BM.stop;
        for (int n = 0; n < 400 && busy !== 1'b0; n++) begin
            @(posedge mclk);
        end
        #1;
        chk({8'h0, busy}, 9'h0);
        point(14'h3fff);
        BM.start;
        wr({DEV, 1'b1}, 1'b0);
        rd(8'h5a, 1'b0);
        rd(ERASED_BYTE, 1'b1);
        BM.stop;
        fetch(14'h3fc0, 8'ha5);
    endtask
    task automatic t_protect;
        @(posedge mclk);
        #1 wp = 1'b1;
        point(14'h0010);
        wr(8'h77, 1'b1);
        BM.stop;
        chk({8'h0, busy}, 9'h0);
        @(posedge mclk);
        #1 wp = 1'b0;
        fetch(14'h0010, ERASED_BYTE);
    endtask
    // Counts, verdict and end of run.
    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Two reset cycles preset the filters to the idle level.
    initial begin
        rst = 1'b1;
        wp = 1'b0;
        sel = 3'h5;
        fails = 0;
        compares = 0;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (10) @(posedge mclk);
        t_select;
        t_wrap;
        t_protect;
        final_report;
    end
    // The run needs under a hundred microseconds; a hang counts as a fault.
    initial begin
        #1000000;
        fails++;
        final_report;
    end
endmodule // tb_ee_serial_eeprom
`default_nettype wire
